//--- pkg/pcs_cnt_if.sv
// interface: settings and outputs of one post-scale counter
`timescale 1ns/1ns
interface pcs_cnt_if
    import pcs_pkg::*;
();
    logic [CNT_W-1:0] high;
    logic [CNT_W-1:0] low;
    logic run;
    logic load;
    logic tick;
    logic clk_out;
    logic carry;
    logic err;
    modport ctl(output high, low, run, load, tick, input clk_out, carry, err);
    modport cnt(input high, low, run, load, tick, output clk_out, carry, err);
endinterface

//--- pkg/pcs_pkg.sv
// package: constants, register map and helpers for the clock synthesizer counters
package pcs_pkg;
    localparam int NUM_CNT = 5;
    localparam int CNT_W = 9;
    localparam int DIV_W = 10;
    localparam int DIV_MAX = 512;
    localparam int ADDR_W = 8;
    localparam int FB_W = 3;
    localparam int FB_MODES = 5;

    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_NDIV = 8'h04;
    localparam logic [ADDR_W-1:0] REG_MDIV = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CHAIN = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_GPIO = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] REG_CNT_BASE = 8'h20;

    localparam int CTRL_LOAD_BIT = 0;
    localparam int CTRL_EN_BIT = 1;
    localparam int CTRL_EXT_LSB = 2;
    localparam int CTRL_FB_LSB = 4;
    localparam int CNT_HI_LSB = 0;
    localparam int CNT_LO_LSB = 9;
    localparam int GPIO_POS_O = 0;
    localparam int GPIO_NEG_O = 1;
    localparam int GPIO_POS_OE = 2;
    localparam int GPIO_NEG_OE = 3;
    localparam int STAT_ERR_LSB = 0;
    localparam int STAT_NERR_BIT = 5;
    localparam int STAT_MERR_BIT = 6;
    localparam int STAT_LOCK_BIT = 7;
    localparam int STAT_PIN_LSB = 8;
    localparam int STAT_OUT_LSB = 10;

    localparam logic [1:0] EXT_GPIO = 2'h0;
    localparam logic [1:0] EXT_SINGLE = 2'h1;
    localparam logic [1:0] EXT_DIFF = 2'h2;
    localparam logic [1:0] EXT_RSVD = 2'h3;

    // compensation modes: source-sync, none, normal, zero delay buffer, latency
    localparam logic [FB_W-1:0] FB_NORMAL = 3'h2;

    localparam logic [DIV_W-1:0] N_RST = 10'h001;
    localparam logic [DIV_W-1:0] M_RST = 10'h001;
    localparam logic [CNT_W-1:0] CNT_HI_RST = 9'h001;
    localparam logic [CNT_W-1:0] CNT_LO_RST = 9'h001;
    localparam logic [NUM_CNT-1:0] CHAIN_RST = 5'h00;
    localparam logic [3:0] GPIO_RST = 4'h0;
    localparam logic [CNT_W:0] SUM_MAX_50 = 10'h200;
    localparam logic [CNT_W:0] SUM_MAX_ANY = 10'h100;

    // equal counts mean 50% duty and allow the longer range
    function automatic logic cnt_ok(input logic [CNT_W-1:0] hi, input logic [CNT_W-1:0] lo);
        logic [CNT_W:0] sum;
        sum = {1'b0, hi} + {1'b0, lo};
        cnt_ok = (hi != '0) && ((hi == lo) ? (sum <= SUM_MAX_50) : (sum <= SUM_MAX_ANY));
    endfunction
endpackage

//--- rtl/pcs_clk_synth.sv
// counter section of the clock synthesizer: registers, dividers, counters, pins
`timescale 1ns/1ns
module pcs_clk_synth
    import pcs_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic REF_CLK_IN,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic PFD_REF_PULSE,
    output logic PFD_FB_PULSE,
    output logic [FB_W-1:0] FB_MODE,
    output logic [NUM_CNT-1:0] GLOBAL_CLK_OUT,
    input wire logic EXT_POS_I,
    output logic EXT_POS_O,
    output logic EXT_POS_OE,
    input wire logic EXT_NEG_I,
    output logic EXT_NEG_O,
    output logic EXT_NEG_OE
);
    logic en_reg;
    logic load_reg;
    logic lock_reg;
    logic [1:0] ext_mode_reg;
    logic [FB_W-1:0] fb_mode_reg;
    logic [DIV_W-1:0] n_reg;
    logic [DIV_W-1:0] m_reg;
    logic [NUM_CNT-1:0] chain_reg;
    logic [3:0] gpio_reg;
    logic [CNT_W-1:0] hi_reg [NUM_CNT];
    logic [CNT_W-1:0] lo_reg [NUM_CNT];
    logic [2:0] s1_reg;
    logic [2:0] s2_reg;
    logic [2:0] s3_reg;
    logic [2:0] filt_reg;
    logic ref_edge;
    logic n_err;
    logic m_err;
    logic pos_o_reg;
    logic neg_o_reg;
    logic pos_oe_reg;
    logic neg_oe_reg;
    logic [31:0] rdata_reg;
    logic [31:0] status;
    logic [NUM_CNT-1:0] cnt_out;
    logic [NUM_CNT-1:0] cnt_err;
    logic [3:0] wr_hit;
    logic [3:0] rd_hit;
    logic ctrl_wr;
    logic [1:0] wr_ext;
    logic [FB_W-1:0] wr_fb;

    pcs_cnt_if cnt_if [NUM_CNT] ();

    // {hit, index} for the block of post-scale counter registers
    function automatic logic [3:0] cnt_hit(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - REG_CNT_BASE;
        cnt_hit = {(a >= REG_CNT_BASE) && (off[1:0] == 2'h0) && (off[ADDR_W-1:2] < NUM_CNT),
            off[4:2]};
    endfunction

    assign wr_hit = cnt_hit(ADDR);
    assign rd_hit = cnt_hit(ADDR);
    assign ctrl_wr = WR && (ADDR == REG_CTRL);
    assign wr_ext = WDATA[CTRL_EXT_LSB +: 2];
    assign wr_fb = WDATA[CTRL_FB_LSB +: FB_W];

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            en_reg <= 1'b0;
        end else if (ctrl_wr) begin
            en_reg <= WDATA[CTRL_EN_BIT];
        end
    end

    // reserved pin mode is ignored so the register only ever holds GPIO, single or differential
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            ext_mode_reg <= EXT_GPIO;
        end else if (ctrl_wr && (wr_ext != EXT_RSVD)) begin
            ext_mode_reg <= wr_ext;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            fb_mode_reg <= FB_NORMAL;
        end else if (ctrl_wr && (wr_fb < FB_W'(FB_MODES))) begin
            fb_mode_reg <= wr_fb;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            load_reg <= 1'b0;
        end else begin
            load_reg <= ctrl_wr && WDATA[CTRL_LOAD_BIT];
        end
    end

    // chaining freezes after the first load
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            lock_reg <= 1'b0;
        end else if (load_reg) begin
            lock_reg <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            chain_reg <= CHAIN_RST;
        end else if (WR && (ADDR == REG_CHAIN) && !lock_reg) begin
            chain_reg <= {WDATA[NUM_CNT-1:1], 1'b0};
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            n_reg <= N_RST;
            m_reg <= M_RST;
        end else if (WR && (ADDR == REG_NDIV)) begin
            n_reg <= WDATA[DIV_W-1:0];
        end else if (WR && (ADDR == REG_MDIV)) begin
            m_reg <= WDATA[DIV_W-1:0];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            gpio_reg <= GPIO_RST;
        end else if (WR && (ADDR == REG_GPIO)) begin
            gpio_reg <= WDATA[3:0];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                hi_reg[i] <= CNT_HI_RST;
                lo_reg[i] <= CNT_LO_RST;
            end
        end else if (WR && wr_hit[3]) begin
            hi_reg[wr_hit[2:0]] <= WDATA[CNT_HI_LSB +: CNT_W];
            lo_reg[wr_hit[2:0]] <= WDATA[CNT_LO_LSB +: CNT_W];
        end
    end

    // pin inputs: three stages, a level counts once stages two and three agree
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            s1_reg <= 3'h0;
            s2_reg <= 3'h0;
            s3_reg <= 3'h0;
            filt_reg <= 3'h0;
        end else begin
            s1_reg <= {EXT_NEG_I, EXT_POS_I, REF_CLK_IN};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
        end
    end

    assign ref_edge = s2_reg[0] && s3_reg[0] && !filt_reg[0];

    pcs_freq_div #(.W(DIV_W), .MAXV(DIV_MAX)) u_prescale (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .run(en_reg),
        .load(load_reg),
        .tick(ref_edge),
        .div(n_reg),
        .pulse(PFD_REF_PULSE),
        .err(n_err)
    );

    // feedback divides the oscillator, which is the core clock here
    pcs_freq_div #(.W(DIV_W), .MAXV(DIV_MAX)) u_feedback (
        .clk(CORE_CLK),
        .rst_n(NRST),
        .run(en_reg),
        .load(load_reg),
        .tick(1'b1),
        .div(m_reg),
        .pulse(PFD_FB_PULSE),
        .err(m_err)
    );

    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
        assign cnt_if[i].high = hi_reg[i];
        assign cnt_if[i].low = lo_reg[i];
        assign cnt_if[i].run = en_reg;
        assign cnt_if[i].load = load_reg;
        assign cnt_out[i] = cnt_if[i].clk_out;
        assign cnt_err[i] = cnt_if[i].err;
        if (i == 0) begin : g_head
            assign cnt_if[i].tick = 1'b1;
        end else begin : g_link
            assign cnt_if[i].tick = chain_reg[i] ? cnt_if[i-1].carry : 1'b1;
        end
        pcs_post_cnt u_cnt (
            .clk(CORE_CLK),
            .rst_n(NRST),
            .ci(cnt_if[i])
        );
    end

    assign GLOBAL_CLK_OUT = cnt_out;
    assign FB_MODE = fb_mode_reg;

    // external pins: only the first counter may be routed here
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            pos_o_reg <= 1'b0;
            neg_o_reg <= 1'b0;
            pos_oe_reg <= 1'b0;
            neg_oe_reg <= 1'b0;
        end else begin
            case (ext_mode_reg)
                EXT_SINGLE: begin
                    pos_o_reg <= cnt_out[0];
                    pos_oe_reg <= 1'b1;
                    neg_o_reg <= gpio_reg[GPIO_NEG_O];
                    neg_oe_reg <= gpio_reg[GPIO_NEG_OE];
                end
                EXT_DIFF: begin
                    pos_o_reg <= cnt_out[0];
                    pos_oe_reg <= 1'b1;
                    neg_o_reg <= !cnt_out[0];
                    neg_oe_reg <= 1'b1;
                end
                default: begin
                    pos_o_reg <= gpio_reg[GPIO_POS_O];
                    pos_oe_reg <= gpio_reg[GPIO_POS_OE];
                    neg_o_reg <= gpio_reg[GPIO_NEG_O];
                    neg_oe_reg <= gpio_reg[GPIO_NEG_OE];
                end
            endcase
        end
    end

    assign EXT_POS_O = pos_o_reg;
    assign EXT_POS_OE = pos_oe_reg;
    assign EXT_NEG_O = neg_o_reg;
    assign EXT_NEG_OE = neg_oe_reg;

    always_comb begin
        status = 32'h0000_0000;
        status[STAT_ERR_LSB +: NUM_CNT] = cnt_err;
        status[STAT_NERR_BIT] = n_err;
        status[STAT_MERR_BIT] = m_err;
        status[STAT_LOCK_BIT] = lock_reg;
        status[STAT_PIN_LSB +: 2] = filt_reg[2:1];
        status[STAT_OUT_LSB +: NUM_CNT] = cnt_out;
    end

    // read data stand only in the cycle after the read strobe
    always_ff @(posedge CORE_CLK) begin
        if (!NRST || !RD) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            case (ADDR)
                REG_CTRL: rdata_reg <= {25'h000_0000, fb_mode_reg, ext_mode_reg, en_reg, 1'b0};
                REG_NDIV: rdata_reg <= {22'h00_0000, n_reg};
                REG_MDIV: rdata_reg <= {22'h00_0000, m_reg};
                REG_CHAIN: rdata_reg <= {27'h000_0000, chain_reg};
                REG_GPIO: rdata_reg <= {28'h000_0000, gpio_reg};
                REG_STATUS: rdata_reg <= status;
                default: begin
                    if (rd_hit[3]) begin
                        rdata_reg <= {14'h0000, lo_reg[rd_hit[2:0]], hi_reg[rd_hit[2:0]]};
                    end else begin
                        rdata_reg <= 32'h0000_0000;
                    end
                end
            endcase
        end
    end

    assign RDATA = rdata_reg;

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence s_diff_mode;
        ext_mode_reg == EXT_DIFF;
    endsequence

    a_ext_first_counter: assert property (
        ext_mode_reg != EXT_GPIO |=> EXT_POS_O == $past(cnt_out[0]) && EXT_POS_OE)
        else $error("external clock pin not fed by first counter");
    a_diff_inverse: assert property (
        s_diff_mode |=> (EXT_NEG_O == !EXT_POS_O) && EXT_NEG_OE)
        else $error("negative pin is not the inverse in differential use");
    a_single_neg_gpio: assert property (
        ext_mode_reg == EXT_SINGLE |=> (EXT_NEG_O == $past(gpio_reg[GPIO_NEG_O]))
            && (EXT_NEG_OE == $past(gpio_reg[GPIO_NEG_OE])))
        else $error("second pin not free in single-ended use");
    a_gpio_pins: assert property (
        ext_mode_reg == EXT_GPIO |=> (EXT_POS_O == $past(gpio_reg[GPIO_POS_O]))
            && (EXT_POS_OE == $past(gpio_reg[GPIO_POS_OE])))
        else $error("external pin not acting as general I/O");
    a_fb_mode_reject: assert property (
        ctrl_wr && (wr_fb >= FB_W'(FB_MODES)) |=> $stable(fb_mode_reg))
        else $error("feedback mode took an unsupported value");
    a_chain_locked: assert property (
        lock_reg && WR && (ADDR == REG_CHAIN) |=> $stable(chain_reg))
        else $error("chaining changed after configuration");

    for (genvar i = 1; i < NUM_CNT; i++) begin : g_chain_chk
        a_chain_step: assert property (
            $changed(cnt_out[i]) && $past(chain_reg[i]) && en_reg && $past(en_reg)
                && !$past(load_reg) |-> $past(cnt_if[i-1].carry))
            else $error("chained counter stepped without upstream carry");
    end
endmodule

//--- rtl/pcs_freq_div.sv
// plain frequency divider for the pre-scale and feedback counters
`timescale 1ns/1ns
module pcs_freq_div
    import pcs_pkg::*;
#(
    parameter int W = DIV_W,
    parameter int MAXV = DIV_MAX
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic load,
    input wire logic tick,
    input wire logic [W-1:0] div,
    output logic pulse,
    output logic err
);
    logic [W-1:0] div_reg;
    logic [W-1:0] cnt_reg;
    logic ok;

    assign ok = (div_reg != '0) && (int'(div_reg) <= MAXV);
    assign err = !ok;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_reg <= W'(1);
        end else if (load) begin
            div_reg <= div;
        end
    end

    // one pulse per div ticks, no duty shaping
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            pulse <= 1'b0;
        end else begin
            pulse <= 1'b0;
            if (!run || load || !ok) begin
                cnt_reg <= '0;
            end else if (tick) begin
                if (cnt_reg == div_reg - W'(1)) begin
                    cnt_reg <= '0;
                    pulse <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + W'(1);
                end
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_div_pulse_cause: assert property (
        pulse |-> $past(tick) && ($past(cnt_reg) == div_reg - W'(1)))
        else $error("divider pulse without terminal count");
    a_div_count_bound: assert property (
        run && ok |-> cnt_reg < div_reg)
        else $error("divider count beyond its setting");
    a_div_pulse_single: assert property (
        pulse && (div_reg != W'(1)) |=> !pulse)
        else $error("divider pulse longer than one cycle");
endmodule

//--- rtl/pcs_post_cnt.sv
// one post-scale counter with separate high and low counts
`timescale 1ns/1ns
module pcs_post_cnt
    import pcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    pcs_cnt_if.cnt ci
);
    typedef enum {PH_IDLE, PH_HIGH, PH_LOW} pcs_phase_e;

    pcs_phase_e phase_reg;
    logic [CNT_W-1:0] hi_reg;
    logic [CNT_W-1:0] lo_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] len_reg;
    logic out_reg;
    logic carry_reg;
    logic ok;

    assign ok = cnt_ok(hi_reg, lo_reg);
    assign ci.clk_out = out_reg;
    assign ci.carry = carry_reg;
    assign ci.err = !ok;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hi_reg <= CNT_HI_RST;
            lo_reg <= CNT_LO_RST;
        end else if (ci.load) begin
            hi_reg <= ci.high;
            lo_reg <= ci.low;
        end
    end

    // carry marks the start of each period except the first after load or idle; it ticks a chained successor
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_reg <= PH_IDLE;
            cnt_reg <= '0;
            out_reg <= 1'b0;
            carry_reg <= 1'b0;
        end else begin
            carry_reg <= 1'b0;
            if (!ci.run) begin
                phase_reg <= PH_IDLE;
                cnt_reg <= '0;
                out_reg <= 1'b0;
            end else if (ci.load) begin
                cnt_reg <= '0;
                if (cnt_ok(ci.high, ci.low)) begin
                    phase_reg <= PH_HIGH;
                    out_reg <= 1'b1;
                end else begin
                    phase_reg <= PH_IDLE;
                    out_reg <= 1'b0;
                end
            end else if (ci.tick) begin
                case (phase_reg)
                    PH_IDLE: begin
                        if (ok) begin
                            phase_reg <= PH_HIGH;
                            out_reg <= 1'b1;
                            cnt_reg <= '0;
                        end
                    end
                    PH_HIGH: begin
                        if (cnt_reg == hi_reg - CNT_W'(1)) begin
                            cnt_reg <= '0;
                            if (lo_reg != '0) begin
                                phase_reg <= PH_LOW;
                                out_reg <= 1'b0;
                            end else begin
                                carry_reg <= 1'b1;
                            end
                        end else begin
                            cnt_reg <= cnt_reg + CNT_W'(1);
                        end
                    end
                    PH_LOW: begin
                        if (cnt_reg == lo_reg - CNT_W'(1)) begin
                            phase_reg <= PH_HIGH;
                            out_reg <= 1'b1;
                            cnt_reg <= '0;
                            carry_reg <= 1'b1;
                        end else begin
                            cnt_reg <= cnt_reg + CNT_W'(1);
                        end
                    end
                    default: phase_reg <= PH_IDLE;
                endcase
            end
        end
    end

    // helper: ticks seen while the output is high
    always_ff @(posedge clk) begin
        if (!rst_n || !out_reg || ci.load) begin
            len_reg <= '0;
        end else if (ci.tick) begin
            len_reg <= len_reg + CNT_W'(1);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_good_load;
        ci.run && ci.load && cnt_ok(ci.high, ci.low);
    endsequence
    sequence s_fresh_high;
        out_reg && (phase_reg == PH_HIGH) && (cnt_reg == '0);
    endsequence

    a_load_restart: assert property (s_good_load |=> s_fresh_high)
        else $error("counter did not restart on load");
    a_high_time: assert property (
        $fell(out_reg) && (phase_reg == PH_LOW) |-> len_reg == hi_reg)
        else $error("high time differs from high count");
    a_range_ok: assert property (phase_reg != PH_IDLE |-> cnt_ok(hi_reg, lo_reg))
        else $error("counter running with divide out of range");
endmodule

//--- tb/tb_pcs_clk_synth.sv
// testbench: register access and counter waveforms of the clock synthesizer
`timescale 1ns/1ns
module tb_pcs_clk_synth import pcs_pkg::*;;
    logic CORE_CLK = 1'b0;
    logic NRST = 1'b0;
    logic REF_CLK_IN = 1'b0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [ADDR_W-1:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0000_0000;
    logic [31:0] RDATA;
    logic PFD_REF_PULSE, PFD_FB_PULSE, EXT_POS_O, EXT_POS_OE, EXT_NEG_O, EXT_NEG_OE;
    logic [FB_W-1:0] FB_MODE;
    logic [NUM_CNT-1:0] GLOBAL_CLK_OUT;
    logic [7:0] mon;
    logic [1:0] ref_div = 2'h0;
    logic EXT_POS_I = 1'b1;
    logic EXT_NEG_I = 1'b0;
    int n_fail = 0;
    int total_checks = 0;

    assign mon = {PFD_REF_PULSE, EXT_POS_O, PFD_FB_PULSE, GLOBAL_CLK_OUT};

    pcs_clk_synth dut (.CORE_CLK(CORE_CLK), .NRST(NRST), .REF_CLK_IN(REF_CLK_IN),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .PFD_REF_PULSE(PFD_REF_PULSE), .PFD_FB_PULSE(PFD_FB_PULSE), .FB_MODE(FB_MODE),
        .GLOBAL_CLK_OUT(GLOBAL_CLK_OUT), .EXT_POS_I(EXT_POS_I), .EXT_POS_O(EXT_POS_O),
        .EXT_POS_OE(EXT_POS_OE), .EXT_NEG_I(EXT_NEG_I), .EXT_NEG_O(EXT_NEG_O),
        .EXT_NEG_OE(EXT_NEG_OE));

    always #5 CORE_CLK = ~CORE_CLK;
    // reference edge every 4 core cycles
    always @(posedge CORE_CLK) begin
        ref_div <= ref_div + 2'h1;
        REF_CLK_IN <= ref_div[1];
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CORE_CLK);
        WR <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge CORE_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CORE_CLK);
        RD <= 1'b0;
        #1;
        chk(RDATA & m, exp);
    endtask

    task automatic wt(input int i, input logic v);
        int k;
        for (k = 0; k < 1200 && mon[i] !== v; k++) begin
            @(posedge CORE_CLK);
            #1;
        end
        if (k == 1200) begin
            n_fail++;
            $display("mismatch at %0t: wait timed out", $time);
            stop_test();
        end
    endtask

    // high and low run lengths of one monitored output
    task automatic meas(input int i, input int eh, input int el);
        int h;
        int l;
        h = 0;
        l = 0;
        wt(i, 1'b0);
        wt(i, 1'b1);
        while (mon[i] === 1'b1 && h < 600) begin
            h++;
            @(posedge CORE_CLK);
            #1;
        end
        while (mon[i] === 1'b0 && l < 600) begin
            l++;
            @(posedge CORE_CLK);
            #1;
        end
        chk(h, eh);
        chk(l, el);
    endtask

    initial begin
        repeat (3) @(posedge CORE_CLK);
        NRST <= 1'b1;
        rd(REG_NDIV, 32'h0000_0001, 32'hFFFF_FFFF);
        rd(REG_CNT_BASE, 32'h0000_0201, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
        chk(32'(FB_MODE), 32'(FB_NORMAL));
        chk(32'(GLOBAL_CLK_OUT), 32'h0000_0000);
        $display("test reset done");
        wr(REG_CHAIN, 32'h0000_0002);
        wr(REG_CNT_BASE, 32'h0000_0402);
        wr(REG_MDIV, 32'h0000_0005);
        wr(REG_NDIV, 32'h0000_0003);
        wr(REG_CTRL, 32'h0000_002B);
        meas(0, 2, 2);
        meas(1, 4, 4);
        meas(5, 1, 4);
        meas(7, 1, 11);
        meas(6, 2, 2);
        chk({EXT_NEG_O, EXT_POS_OE, EXT_NEG_OE}, {~EXT_POS_O, 2'b11});
        rd(REG_STATUS, 32'h0000_0180, 32'h0000_03FF);
        wr(REG_CHAIN, 32'h0000_0000);
        rd(REG_CHAIN, 32'h0000_0002, 32'hFFFF_FFFF);
        $display("test chain done");
        wr(REG_CNT_BASE + 8'h08, 32'h0000_0607);
        wr(REG_CNT_BASE + 8'h0C, 32'h0002_0100);
        wr(REG_CNT_BASE + 8'h10, 32'h0000_C8C8);
        wr(REG_CTRL, 32'h0000_002B);
        meas(2, 7, 3);
        meas(3, 256, 256);
        chk(32'(GLOBAL_CLK_OUT[4]), 32'h0000_0000);
        rd(REG_STATUS, 32'h0000_0090, 32'h0000_00FF);
        $display("test duty done");
        for (int f = 0; f < 5; f++) begin
            wr(REG_CTRL, 32'h0000_000A | 32'(f << 4));
            chk(32'(FB_MODE), 32'(f));
        end
        wr(REG_CTRL, 32'h0000_005A);
        chk(32'(FB_MODE), 32'h0000_0004);
        $display("test modes done");
        wr(REG_GPIO, 32'h0000_000D);
        wr(REG_CTRL, 32'h0000_0006);
        meas(6, 2, 2);
        chk({EXT_POS_OE, EXT_NEG_O, EXT_NEG_OE}, 3'b101);
        wr(REG_CTRL, 32'h0000_0002);
        // pins are registered one cycle after the mode changes
        @(posedge CORE_CLK);
        #1;
        chk({EXT_POS_O, EXT_POS_OE, EXT_NEG_O, EXT_NEG_OE}, 4'b1101);
        @(posedge CORE_CLK);
        EXT_POS_I <= 1'b0;
        EXT_NEG_I <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        rd(REG_STATUS, 32'h0000_0200, 32'h0000_0300);
        $display("test pins done");
        wr(REG_NDIV, 32'h0000_0000);
        wr(REG_CTRL, 32'h0000_0003);
        rd(REG_STATUS, 32'h0000_0020, 32'h0000_0020);
        $display("test divider done");
        @(posedge CORE_CLK);
        NRST <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
        NRST <= 1'b1;
        #1;
        chk(32'(FB_MODE), 32'(FB_NORMAL));
        chk(32'(GLOBAL_CLK_OUT), 32'h0000_0000);
        chk({EXT_POS_O, EXT_POS_OE, EXT_NEG_O, EXT_NEG_OE}, 4'h0);
        wr(REG_CHAIN, 32'h0000_0004);
        rd(REG_CHAIN, 32'h0000_0004, 32'hFFFF_FFFF);
        $display("test restart done");
        stop_test();
    end
endmodule
